/* File: core/dbsc_pkg.sv */
// What this block does
// - Deselect or no-op lets a read burst with auto close run to its end.
// - Deselect or no-op lets a write burst with auto close run to its end.
// - A closing bank under idle commands becomes idle after the row close time.
// - Closing a bank that is already closing is a no-op; idle still follows.
// - An activating bank becomes active after the activate-to-column delay.
// - Write recovery after a plain write returns to active after recovery time.
// - Refresh returns to idle after refresh cycle time; other commands illegal.
// - Mode set returns to idle after mode set delay; other commands illegal.
// - Illegal commands are flagged as protocol violations and otherwise ignored.
`default_nettype none
package dbsc_pkg;
   localparam int NUM_BANKS     = 4;
   localparam int BANK_WIDTH    = 2;
   localparam int TIMER_WIDTH   = 8;
   localparam int CLK_PERIOD_NS = 20;

   // Plain defaults; the real figures depend on the speed grade
   localparam int ROW_CLOSE_TIME_NS          = 15;
   localparam int ACTIVATE_TO_COLUMN_NS      = 15;
   localparam int WRITE_RECOVERY_TIME_NS     = 15;
   localparam int REFRESH_CYCLE_TIME_NS      = 105;
   localparam int MODE_SET_DELAY_NS          = 40;
   localparam int BURST_CLOCKS               = 2;

   localparam logic [TIMER_WIDTH-1:0] ROW_CLOSE_CYCLES =
      TIMER_WIDTH'((ROW_CLOSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TIMER_WIDTH-1:0] ACT_TO_COL_CYCLES =
      TIMER_WIDTH'((ACTIVATE_TO_COLUMN_NS + CLK_PERIOD_NS - 1)
                   / CLK_PERIOD_NS);
   localparam logic [TIMER_WIDTH-1:0] WRITE_RECOVERY_CYCLES =
      TIMER_WIDTH'((WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1)
                   / CLK_PERIOD_NS);
   localparam logic [TIMER_WIDTH-1:0] REFRESH_CYCLES =
      TIMER_WIDTH'((REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1)
                   / CLK_PERIOD_NS);
   localparam logic [TIMER_WIDTH-1:0] MODE_SET_CYCLES =
      TIMER_WIDTH'((MODE_SET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TIMER_WIDTH-1:0] BURST_CYCLES =
      TIMER_WIDTH'(BURST_CLOCKS);
   localparam logic [TIMER_WIDTH-1:0] TIMER_LAST  = 8'h01;
   localparam logic [TIMER_WIDTH-1:0] TIMER_CLEAR = 8'h00;

   typedef struct packed {
      logic                  csN;
      logic                  rasN;
      logic                  casN;
      logic                  weN;
      logic [BANK_WIDTH-1:0] bank;
      logic                  a10;
   } dbsc_cmd_bus_type;

   typedef enum logic [2:0] {
      CMD_DESELECT, CMD_NOP, CMD_READ, CMD_WRITE,
      CMD_ACTIVATE, CMD_CLOSE, CMD_REFRESH, CMD_MODE_SET
   } dbsc_cmd_type;

   typedef enum logic [3:0] {
      BANK_IDLE, BANK_ACTIVATING, BANK_ACTIVE, BANK_READ, BANK_WRITE,
      BANK_READ_AUTO, BANK_WRITE_AUTO, BANK_WRITE_RECOV,
      BANK_WRITE_RECOV_AUTO, BANK_CLOSING
   } dbsc_bank_state_type;

   typedef enum logic [1:0] {
      DEV_READY, DEV_REFRESHING, DEV_MODE_SETTING
   } dbsc_dev_state_type;
endpackage
`default_nettype wire

/* File: core/dbsc_bank_check.sv */
`default_nettype none
module dbsc_bank_check (
   input  wire logic                         core_clk,    // 50 MHz clock
   input  wire logic                         rst,         // Sync reset
   input  wire logic                         clkEn,       // Freezes state low
   input  wire dbsc_pkg::dbsc_cmd_bus_type   cmdBus,      // Command pins
   output var  dbsc_pkg::dbsc_bank_state_type
                  [dbsc_pkg::NUM_BANKS-1:0] bankState_q, // Per-bank state
   output var  dbsc_pkg::dbsc_dev_state_type devState_q,  // Refresh/mode set
   output logic [dbsc_pkg::NUM_BANKS-1:0]    bankIdle_q,  // Bank is idle
   output logic                              illegalCmd_q, // Violation pulse
   output logic                              noopCmd_q    // Cmd had no effect
);
   // Command decode from the four control pins
   wire logic [2:0] ctlPins = {cmdBus.rasN, cmdBus.casN, cmdBus.weN};
   dbsc_pkg::dbsc_cmd_type cmdKind;
   assign cmdKind = cmdBus.csN           ? dbsc_pkg::CMD_DESELECT :
                    (ctlPins == 3'h7)    ? dbsc_pkg::CMD_NOP      :
                    (ctlPins == 3'h5)    ? dbsc_pkg::CMD_READ     :
                    (ctlPins == 3'h4)    ? dbsc_pkg::CMD_WRITE    :
                    (ctlPins == 3'h3)    ? dbsc_pkg::CMD_ACTIVATE :
                    (ctlPins == 3'h2)    ? dbsc_pkg::CMD_CLOSE    :
                    (ctlPins == 3'h1)    ? dbsc_pkg::CMD_REFRESH  :
                                           dbsc_pkg::CMD_MODE_SET;

   wire logic isIdleCmd  = (cmdKind == dbsc_pkg::CMD_DESELECT)
                        || (cmdKind == dbsc_pkg::CMD_NOP);
   wire logic isCloseAll = (cmdKind == dbsc_pkg::CMD_CLOSE) && cmdBus.a10;
   wire logic isGlobal   = (cmdKind == dbsc_pkg::CMD_REFRESH)
                        || (cmdKind == dbsc_pkg::CMD_MODE_SET);
   wire logic devBusy    = (devState_q != dbsc_pkg::DEV_READY);

   logic [dbsc_pkg::TIMER_WIDTH-1:0] devTimer_q;
   logic [dbsc_pkg::TIMER_WIDTH-1:0] devTimer_d;
   dbsc_pkg::dbsc_dev_state_type     devState_d;

   logic [dbsc_pkg::NUM_BANKS-1:0] bankReject;
   logic [dbsc_pkg::NUM_BANKS-1:0] bankNoop;
   logic [dbsc_pkg::NUM_BANKS-1:0] bankIdleNow;
   logic [dbsc_pkg::NUM_BANKS-1:0] bankIdle_d;

   // Refresh and mode set need every bank idle; while one runs, only
   // idle commands are accepted by anyone
   wire logic allIdle = &bankIdleNow;
   wire logic globalReject = devBusy ? !isIdleCmd
                                     : (isGlobal && !allIdle);
   wire logic cmdIllegal   = globalReject || (|bankReject);
   wire logic commit       = !cmdIllegal && !devBusy;
   wire logic cmdNoop      = !cmdIllegal && (isIdleCmd || (|bankNoop));

   genvar b;
   generate
      for (b = 0; b < dbsc_pkg::NUM_BANKS; b++)
      begin : g_bank
         logic [dbsc_pkg::TIMER_WIDTH-1:0] timer_q;
         logic [dbsc_pkg::TIMER_WIDTH-1:0] timer_d;
         dbsc_pkg::dbsc_bank_state_type    state_d;

         wire logic hit = (cmdBus.bank == dbsc_pkg::BANK_WIDTH'(b))
                       && !isIdleCmd && !isGlobal && !isCloseAll;
         wire logic timerDone = (timer_q == dbsc_pkg::TIMER_LAST);
         wire dbsc_pkg::dbsc_bank_state_type st = bankState_q[b];

         wire logic isRd  = hit && (cmdKind == dbsc_pkg::CMD_READ);
         wire logic isWr  = hit && (cmdKind == dbsc_pkg::CMD_WRITE);
         wire logic isAct = hit && (cmdKind == dbsc_pkg::CMD_ACTIVATE);
         wire logic isCls = hit && (cmdKind == dbsc_pkg::CMD_CLOSE);

         wire logic stable = (st == dbsc_pkg::BANK_IDLE)
                          || (st == dbsc_pkg::BANK_ACTIVE)
                          || (st == dbsc_pkg::BANK_CLOSING);

         // Only the addressed bank judges a single-bank command
         wire logic rejIdle    = isRd || isWr;
         wire logic rejActive  = isAct;
         wire logic rejRead    = isWr || isAct || isCls;
         wire logic rejWrite   = isRd || isAct || isCls;
         wire logic rejRecov   = isRd || isAct || isCls;
         wire logic rejClosing = isRd || isWr || isAct;
         assign bankReject[b] =
            (isCloseAll && !stable)
            || ((st == dbsc_pkg::BANK_IDLE)             && rejIdle)
            || ((st == dbsc_pkg::BANK_ACTIVE)           && rejActive)
            || ((st == dbsc_pkg::BANK_READ)             && rejRead)
            || ((st == dbsc_pkg::BANK_WRITE)            && rejWrite)
            || ((st == dbsc_pkg::BANK_WRITE_RECOV)      && rejRecov)
            || ((st == dbsc_pkg::BANK_CLOSING)          && rejClosing)
            || ((st == dbsc_pkg::BANK_ACTIVATING)       && hit)
            || ((st == dbsc_pkg::BANK_READ_AUTO)        && hit)
            || ((st == dbsc_pkg::BANK_WRITE_AUTO)       && hit)
            || ((st == dbsc_pkg::BANK_WRITE_RECOV_AUTO) && hit);
         assign bankNoop[b] = (st == dbsc_pkg::BANK_CLOSING)
                           && (isCls || isCloseAll);
         assign bankIdleNow[b] = (st == dbsc_pkg::BANK_IDLE);

         always_comb
         begin
            state_d = st;
            timer_d = (timer_q > dbsc_pkg::TIMER_LAST)
                      ? timer_q - dbsc_pkg::TIMER_LAST : timer_q;
            case (st)
               dbsc_pkg::BANK_ACTIVATING:
                  if (timerDone)
                  begin
                     state_d = dbsc_pkg::BANK_ACTIVE;
                     timer_d = dbsc_pkg::TIMER_CLEAR;
                  end
               dbsc_pkg::BANK_READ,
               dbsc_pkg::BANK_WRITE_RECOV:
                  if (timerDone)
                  begin
                     state_d = dbsc_pkg::BANK_ACTIVE;
                     timer_d = dbsc_pkg::TIMER_CLEAR;
                  end
               dbsc_pkg::BANK_WRITE:
                  if (timerDone)
                  begin
                     state_d = dbsc_pkg::BANK_WRITE_RECOV;
                     timer_d = dbsc_pkg::WRITE_RECOVERY_CYCLES;
                  end
               dbsc_pkg::BANK_WRITE_AUTO:
                  if (timerDone)
                  begin
                     state_d = dbsc_pkg::BANK_WRITE_RECOV_AUTO;
                     timer_d = dbsc_pkg::WRITE_RECOVERY_CYCLES;
                  end
               dbsc_pkg::BANK_READ_AUTO,
               dbsc_pkg::BANK_WRITE_RECOV_AUTO:
                  if (timerDone)
                  begin
                     state_d = dbsc_pkg::BANK_CLOSING;
                     timer_d = dbsc_pkg::ROW_CLOSE_CYCLES;
                  end
               dbsc_pkg::BANK_CLOSING:
                  if (timerDone)
                  begin
                     state_d = dbsc_pkg::BANK_IDLE;
                     timer_d = dbsc_pkg::TIMER_CLEAR;
                  end
               default:
                  ;
            endcase
            // Accepted commands override the timed progression
            if (commit)
            begin
               if (st == dbsc_pkg::BANK_IDLE && isAct)
               begin
                  state_d = dbsc_pkg::BANK_ACTIVATING;
                  timer_d = dbsc_pkg::ACT_TO_COL_CYCLES;
               end
               else if (st == dbsc_pkg::BANK_ACTIVE && (isCls || isCloseAll))
               begin
                  state_d = dbsc_pkg::BANK_CLOSING;
                  timer_d = dbsc_pkg::ROW_CLOSE_CYCLES;
               end
               else if (isRd && (st == dbsc_pkg::BANK_ACTIVE
                                 || st == dbsc_pkg::BANK_READ))
               begin
                  state_d = cmdBus.a10 ? dbsc_pkg::BANK_READ_AUTO
                                       : dbsc_pkg::BANK_READ;
                  timer_d = dbsc_pkg::BURST_CYCLES;
               end
               else if (isWr && (st == dbsc_pkg::BANK_ACTIVE
                                 || st == dbsc_pkg::BANK_WRITE
                                 || st == dbsc_pkg::BANK_WRITE_RECOV))
               begin
                  state_d = cmdBus.a10 ? dbsc_pkg::BANK_WRITE_AUTO
                                       : dbsc_pkg::BANK_WRITE;
                  timer_d = dbsc_pkg::BURST_CYCLES;
               end
            end
         end

         assign bankIdle_d[b] = (state_d == dbsc_pkg::BANK_IDLE);

         always_ff @(posedge core_clk)
         begin
            if (rst)
            begin
               bankState_q[b] <= dbsc_pkg::BANK_IDLE;
               timer_q        <= dbsc_pkg::TIMER_CLEAR;
            end
            else if (clkEn)
            begin
               bankState_q[b] <= state_d;
               timer_q        <= timer_d;
            end
         end
      end
   endgenerate

   // Device-wide refresh and mode set sequencing
   always_comb
   begin
      devState_d = devState_q;
      devTimer_d = (devTimer_q > dbsc_pkg::TIMER_LAST)
                   ? devTimer_q - dbsc_pkg::TIMER_LAST : devTimer_q;
      case (devState_q)
         dbsc_pkg::DEV_READY:
            if (!cmdIllegal && cmdKind == dbsc_pkg::CMD_REFRESH)
            begin
               devState_d = dbsc_pkg::DEV_REFRESHING;
               devTimer_d = dbsc_pkg::REFRESH_CYCLES;
            end
            else if (!cmdIllegal && cmdKind == dbsc_pkg::CMD_MODE_SET)
            begin
               devState_d = dbsc_pkg::DEV_MODE_SETTING;
               devTimer_d = dbsc_pkg::MODE_SET_CYCLES;
            end
         dbsc_pkg::DEV_REFRESHING,
         dbsc_pkg::DEV_MODE_SETTING:
            if (devTimer_q == dbsc_pkg::TIMER_LAST)
            begin
               devState_d = dbsc_pkg::DEV_READY;
               devTimer_d = dbsc_pkg::TIMER_CLEAR;
            end
         default:
            devState_d = dbsc_pkg::DEV_READY;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         devState_q   <= dbsc_pkg::DEV_READY;
         devTimer_q   <= dbsc_pkg::TIMER_CLEAR;
         bankIdle_q   <= '1;
         illegalCmd_q <= 1'b0;
         noopCmd_q    <= 1'b0;
      end
      else if (clkEn)
      begin
         devState_q   <= devState_d;
         devTimer_q   <= devTimer_d;
         bankIdle_q   <= bankIdle_d;
         illegalCmd_q <= cmdIllegal;
         noopCmd_q    <= cmdNoop;
      end
   end
endmodule
`default_nettype wire

/* File: verif/dbsc_bank_check_monitor.sv */
`default_nettype none
module dbsc_bank_check_monitor (
   input wire logic                       core_clk,     // Clock
   input wire logic                       rst,          // Sync reset
   input wire logic                       clkEn,        // Clock enable
   input wire dbsc_pkg::dbsc_cmd_bus_type cmdBus,       // Command pins
   input var  dbsc_pkg::dbsc_bank_state_type
                 [dbsc_pkg::NUM_BANKS-1:0] bankState_q, // Bank states
   input var  dbsc_pkg::dbsc_dev_state_type devState_q, // Device state
   input wire logic [dbsc_pkg::NUM_BANKS-1:0] bankIdle_q, // Idle banks
   input wire logic                       illegalCmd_q, // Violation
   input wire logic                       noopCmd_q     // No-op seen
);
   timeunit 1ns;
   timeprecision 1ns;
   dbsc_pkg::dbsc_bank_state_type b0;
   wire logic [2:0] pins = {cmdBus.rasN, cmdBus.casN, cmdBus.weN};
   wire logic       sel0 = !cmdBus.csN && cmdBus.bank == 2'h0;
   wire logic       read0 = sel0 && pins == 3'h5;
   wire logic       close0 = sel0 && pins == 3'h2 && !cmdBus.a10;
   wire logic       closeAll = !cmdBus.csN && pins == 3'h2 && cmdBus.a10;
   assign b0 = bankState_q[0];
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   readBurst_a: assert property (
      b0 == dbsc_pkg::BANK_READ_AUTO |=>
      b0 inside {dbsc_pkg::BANK_READ_AUTO, dbsc_pkg::BANK_CLOSING})
      else $error("read burst with auto close cut short");
   writeBurst_a: assert property (
      b0 == dbsc_pkg::BANK_WRITE_AUTO |=> b0 inside
      {dbsc_pkg::BANK_WRITE_AUTO, dbsc_pkg::BANK_WRITE_RECOV_AUTO})
      else $error("write burst with auto close cut short");
   closeDone_a: assert property (
      b0 == dbsc_pkg::BANK_CLOSING && clkEn |=>
      b0 == dbsc_pkg::BANK_IDLE && bankIdle_q[0])
      else $error("closing bank not idle after close time");
   closeTwice_a: assert property (
      b0 == dbsc_pkg::BANK_CLOSING && clkEn && close0 |=>
      noopCmd_q && !illegalCmd_q)
      else $error("close to closing bank not a no-op");
   activateDone_a: assert property (
      b0 == dbsc_pkg::BANK_ACTIVATING && clkEn |=>
      b0 == dbsc_pkg::BANK_ACTIVE)
      else $error("bank not active after activate delay");
   recovRead_a: assert property (
      b0 == dbsc_pkg::BANK_WRITE_RECOV && clkEn && read0 |=>
      illegalCmd_q && b0 == dbsc_pkg::BANK_ACTIVE)
      else $error("read in write recovery not flagged");
   refreshDone_a: assert property (
      $rose(devState_q == dbsc_pkg::DEV_REFRESHING) ##0 clkEn [*6] |->
      devState_q == dbsc_pkg::DEV_REFRESHING ##1
      devState_q == dbsc_pkg::DEV_READY)
      else $error("refresh not over after refresh cycle time");
   closeAllBusy_a: assert property (
      b0 == dbsc_pkg::BANK_READ_AUTO && clkEn && closeAll |=>
      illegalCmd_q && !noopCmd_q)
      else $error("close-all during burst not flagged");
   cover property (b0 == dbsc_pkg::BANK_WRITE_RECOV_AUTO);
   cover property (devState_q == dbsc_pkg::DEV_MODE_SETTING);
   cover property (illegalCmd_q && clkEn);
endmodule
bind dbsc_bank_check dbsc_bank_check_monitor monitor (
   .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .cmdBus(cmdBus),
   .bankState_q(bankState_q), .devState_q(devState_q),
   .bankIdle_q(bankIdle_q), .illegalCmd_q(illegalCmd_q),
   .noopCmd_q(noopCmd_q));
`default_nettype wire

/* File: verif/dbsc_ctrl_model.sv */
`default_nettype none
module dbsc_ctrl_model (
   input wire logic                       core_clk, // Clock
   input var  dbsc_pkg::dbsc_cmd_type     reqCmd,   // Command to send
   input wire logic [1:0]                 reqBank,  // Target bank
   input wire logic                       reqA10,   // Auto close or all
   output var dbsc_pkg::dbsc_cmd_bus_type cmdBus    // Command pins
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] filler_q = 6'h2a;
   wire logic [2:0] pins =
      reqCmd == dbsc_pkg::CMD_NOP ? 3'h7 : 3'h7 - 3'(reqCmd);
   // Unselected pins carry a pattern that flips every cycle
   always @(posedge core_clk)
      filler_q <= ~filler_q;
   // Sends only what is requested; illegal ones only when the bench asks
   assign cmdBus = reqCmd == dbsc_pkg::CMD_DESELECT ? {1'b1, filler_q}
      : {1'b0, pins, reqBank, reqA10};
endmodule
`default_nettype wire

/* File: verif/dbsc_testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                               core_clk = 1'b0;
   logic                               rst = 1'b1;
   logic                               clkEn = 1'b1;
   dbsc_pkg::dbsc_cmd_type             reqCmd = dbsc_pkg::CMD_NOP;
   logic [1:0]                         reqBank = 2'h0;
   logic                               reqA10 = 1'b0;
   dbsc_pkg::dbsc_cmd_bus_type         cmdBus;
   dbsc_pkg::dbsc_bank_state_type [3:0] bankState_q;
   dbsc_pkg::dbsc_dev_state_type       devState_q;
   logic [3:0]                         bankIdle_q;
   logic                               illegalCmd_q;
   logic                               noopCmd_q;
   int                                 mismatches = 0;
   int                                 testsRun = 0;
   dbsc_pkg::dbsc_bank_state_type      ms [4];
   int                                 mt [4];
   dbsc_pkg::dbsc_dev_state_type       md;
   int                                 mdt;
   logic                               mIll;
   logic                               mNop;
   int dir [$] = {700, 400, 100, 600, 400, 100, 100, 100, 100, 100,
      400, 200, 201, 501, 100, 500,
      400, 100, 300, 100, 100, 200, 300, 100, 100, 301,
      410, 200, 200, 501, 100, 100, 100};
   dbsc_ctrl_model ctrl (.core_clk(core_clk), .reqCmd(reqCmd),
      .reqBank(reqBank), .reqA10(reqA10), .cmdBus(cmdBus));
   dbsc_bank_check dut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
      .cmdBus(cmdBus), .bankState_q(bankState_q), .devState_q(devState_q),
      .bankIdle_q(bankIdle_q), .illegalCmd_q(illegalCmd_q),
      .noopCmd_q(noopCmd_q));
   initial
   begin
      forever #10 core_clk = ~core_clk;
   end
   task put(int i, dbsc_pkg::dbsc_bank_state_type v, int n);
      ms[i] = v;
      mt[i] = n;
   endtask
   task mstep(dbsc_pkg::dbsc_cmd_type c, int b, bit a, bit e);
      dbsc_pkg::dbsc_bank_state_type s;
      bit ok;
      bit [3:0] q;
      bit [3:0] idl;
      bit [3:0] cl;
      if (!e)
         return;
      s = ms[b];
      foreach (ms[i])
      begin
         idl[i] = ms[i] == dbsc_pkg::BANK_IDLE;
         cl[i] = ms[i] == dbsc_pkg::BANK_CLOSING;
         q[i] = idl[i] || ms[i] inside
            {dbsc_pkg::BANK_ACTIVE, dbsc_pkg::BANK_CLOSING};
      end
      case (c)
         dbsc_pkg::CMD_READ:
            ok = s inside {dbsc_pkg::BANK_ACTIVE, dbsc_pkg::BANK_READ};
         dbsc_pkg::CMD_WRITE:
            ok = s inside {dbsc_pkg::BANK_ACTIVE, dbsc_pkg::BANK_WRITE,
                           dbsc_pkg::BANK_WRITE_RECOV};
         dbsc_pkg::CMD_ACTIVATE: ok = idl[b];
         dbsc_pkg::CMD_CLOSE: ok = a ? &q : q[b];
         dbsc_pkg::CMD_REFRESH, dbsc_pkg::CMD_MODE_SET: ok = &idl;
         default: ok = 1;
      endcase
      if (c > dbsc_pkg::CMD_NOP && md != dbsc_pkg::DEV_READY)
         ok = 0;
      mIll = !ok;
      // Close-all counts as a no-op once any bank is already closing
      mNop = c <= dbsc_pkg::CMD_NOP || ok && c == dbsc_pkg::CMD_CLOSE
         && (a ? |cl : s == dbsc_pkg::BANK_CLOSING);
      foreach (mt[i])
      begin
         if (mt[i] > 0)
            mt[i]--;
         if (mt[i] == 0)
            case (ms[i])
               dbsc_pkg::BANK_WRITE: put(i, dbsc_pkg::BANK_WRITE_RECOV,
                  dbsc_pkg::WRITE_RECOVERY_CYCLES);
               dbsc_pkg::BANK_WRITE_AUTO: put(i,
                  dbsc_pkg::BANK_WRITE_RECOV_AUTO,
                  dbsc_pkg::WRITE_RECOVERY_CYCLES);
               dbsc_pkg::BANK_READ_AUTO, dbsc_pkg::BANK_WRITE_RECOV_AUTO:
                  put(i, dbsc_pkg::BANK_CLOSING, dbsc_pkg::ROW_CLOSE_CYCLES);
               dbsc_pkg::BANK_CLOSING: put(i, dbsc_pkg::BANK_IDLE, 0);
               dbsc_pkg::BANK_IDLE, dbsc_pkg::BANK_ACTIVE: ;
               default: put(i, dbsc_pkg::BANK_ACTIVE, 0);
            endcase
      end
      if (mdt > 0)
         mdt--;
      if (mdt == 0)
         md = dbsc_pkg::DEV_READY;
      if (ok)
         case (c)
            dbsc_pkg::CMD_READ: put(b, a ? dbsc_pkg::BANK_READ_AUTO
               : dbsc_pkg::BANK_READ, dbsc_pkg::BURST_CYCLES);
            dbsc_pkg::CMD_WRITE: put(b, a ? dbsc_pkg::BANK_WRITE_AUTO
               : dbsc_pkg::BANK_WRITE, dbsc_pkg::BURST_CYCLES);
            dbsc_pkg::CMD_ACTIVATE: put(b, dbsc_pkg::BANK_ACTIVATING,
               dbsc_pkg::ACT_TO_COL_CYCLES);
            dbsc_pkg::CMD_CLOSE:
               foreach (ms[i])
                  if ((a || i == b) && ms[i] == dbsc_pkg::BANK_ACTIVE)
                     put(i, dbsc_pkg::BANK_CLOSING,
                         dbsc_pkg::ROW_CLOSE_CYCLES);
            dbsc_pkg::CMD_REFRESH:
            begin
               md = dbsc_pkg::DEV_REFRESHING;
               mdt = dbsc_pkg::REFRESH_CYCLES;
            end
            dbsc_pkg::CMD_MODE_SET:
            begin
               md = dbsc_pkg::DEV_MODE_SETTING;
               mdt = dbsc_pkg::MODE_SET_CYCLES;
            end
            default: ;
         endcase
   endtask
   task chk(string nm, logic [15:0] seen, logic [15:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task compare();
      logic [15:0] ex;
      logic [3:0] id;
      foreach (ms[i])
      begin
         ex[4*i +: 4] = ms[i];
         id[i] = ms[i] == dbsc_pkg::BANK_IDLE;
      end
      chk("bankState", bankState_q, ex);
      chk("devState", 16'(devState_q), 16'(md));
      chk("bankIdle", 16'(bankIdle_q), 16'(id));
      chk("illegalCmd", 16'(illegalCmd_q), 16'(mIll));
      chk("noopCmd", 16'(noopCmd_q), 16'(mNop));
   endtask
   task go(int c, int b, bit a, bit e);
      reqCmd <= dbsc_pkg::dbsc_cmd_type'(c);
      reqBank <= 2'(b);
      reqA10 <= a;
      clkEn <= e;
      @(negedge core_clk);
      compare();
      mstep(dbsc_pkg::dbsc_cmd_type'(c), b, a, e);
      @(posedge core_clk);
   endtask
   task reset_dut();
      rst <= 1'b1;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      foreach (ms[i]) put(i, dbsc_pkg::BANK_IDLE, 0);
      md = dbsc_pkg::DEV_READY;
      mdt = 0;
      mstep(reqCmd, reqBank, reqA10, clkEn);
      @(posedge core_clk);
   endtask
   task stop_test();
      $display("comparisons %0d mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      int c;
      void'($urandom(32'h519835aa));
      reset_dut();
      foreach (dir[k]) go(dir[k] / 100, dir[k] / 10 % 10, dir[k] % 2, 1);
      reset_dut();
      repeat (600)
      begin
         c = $urandom % 8;
         go(c, $urandom % 4, c != 5 && $urandom % 2, $urandom % 8 != 0);
      end
      go(1, 0, 0, 1);
      stop_test();
   end
endmodule
`default_nettype wire
